//--- common/plc_map.vh
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// ----------------------------------------
// Line levels, two-bit signed code
// ----------------------------------------
`define PLC_LVL_ZERO  2'b00
`define PLC_LVL_PLUS  2'b01
`define PLC_LVL_MINUS 2'b11

// ----------------------------------------
// Timing
// ----------------------------------------
`define PLC_CLK_HZ     10000000
`define PLC_NLP_MS     16
`define PLC_NLP_CYC    ((`PLC_CLK_HZ / 1000) * `PLC_NLP_MS)
`define PLC_NLP_WIDTH  1
`define PLC_NIB_DIV    4
`define PLC_RX_IDLE    8

`endif

//--- hdl/plc_line_coder.v
`include "plc_map.vh"

module plc_line_coder #(
	parameter NLP_CYC  = `PLC_NLP_CYC,
	parameter RX_IDLE  = `PLC_RX_IDLE
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        nrst,
	// Mode
	input  wire        mode_100,
	input  wire        nibble_if,
	// Controller transmit side
	input  wire        tx_en,
	input  wire [3:0]  txd,
	input  wire        tx_nrzi,
	// Controller receive side
	output reg         rx_nrzi_r,
	output reg         rxd_ser_r,
	output reg  [3:0]  rxd_nib_r,
	output reg         rx_dv_r,
	output reg         rx_clk_r,
	output reg         if_clk_r,
	output reg         col_r,
	// Line side, one sample per half bit in 10 Mb/s mode
	output reg  [1:0]  line_tx_r,
	output reg         nlp_r,
	input  wire [1:0]  line_rx,
	input  wire        rx_act
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg rst_s1_r;
	reg rst_n_r;
	always @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// Next level in the 0,+1,0,-1 cycle
	function [1:0] mlt_step;
		input [1:0] cur;
		input       last_pos;
		begin
			if (cur != `PLC_LVL_ZERO)
				mlt_step = `PLC_LVL_ZERO;
			else if (last_pos)
				mlt_step = `PLC_LVL_MINUS;
			else
				mlt_step = `PLC_LVL_PLUS;
		end
	endfunction

	// Split-phase level: a one is high then low, a zero low then high
	function [1:0] man_level;
		input bit_val;
		input second;
		begin
			if (bit_val ^ second)
				man_level = `PLC_LVL_PLUS;
			else
				man_level = `PLC_LVL_MINUS;
		end
	endfunction

	// Line sample reads as high
	function is_high;
		input [1:0] lvl;
		begin
			is_high = (lvl == `PLC_LVL_PLUS);
		end
	endfunction

	// ----------------------------------------
	// Transmit: phase, bit select, encoders
	// ----------------------------------------
	reg         half_r;       // 0 = first half of bit
	reg         half_nxt;
	reg  [1:0]  bit_idx_r;    // bit within nibble
	reg  [1:0]  bit_idx_nxt;
	reg         tx_en_d_r;
	reg  [1:0]  if_div_r;
	reg  [1:0]  if_div_nxt;
	reg         if_clk_nxt;
	reg  [23:0] nlp_cnt_r;
	reg  [23:0] nlp_cnt_nxt;
	reg  [1:0]  mlt_lvl_r;
	reg  [1:0]  mlt_lvl_nxt;
	reg         last_pos_r;   // last nonzero level was +1
	reg         last_pos_nxt;
	reg  [1:0]  line_nxt;
	wire        tx_bit;
	wire        tx_start;
	wire        nlp_hit;
	wire        mlt_one;

	// Nibbles are sent LSB first; serial format uses bit 0
	assign tx_bit   = nibble_if ? txd[bit_idx_r] : txd[0];
	assign tx_start = tx_en && !tx_en_d_r;
	// Pulse due on the last count of an idle interval
	assign nlp_hit  = !mode_100 && !tx_en && (nlp_cnt_r == NLP_CYC - 1);
	assign mlt_one  = mode_100 && tx_en && tx_nrzi;

	// Bit timing, parked at 100 Mb/s so 10 Mb/s restarts on a first half
	always @*
	begin
		half_nxt    = 1'b0;
		bit_idx_nxt = 2'b00;
		if (!mode_100)
		begin
			half_nxt    = !half_r;
			bit_idx_nxt = bit_idx_r;
			if (half_r && !tx_start && tx_en)
				bit_idx_nxt = bit_idx_r + 2'b01;
			else if (half_r)
				bit_idx_nxt = 2'b00;
		end
	end

	// Interface clock runs free at 10 Mb/s so the controller has it while idle; held low at 100 Mb/s
	always @*
	begin
		if_div_nxt = if_div_r;
		if_clk_nxt = 1'b0;
		if (!mode_100)
		begin
			if (half_r)
				if_div_nxt = if_div_r + 2'b01;
			if (nibble_if)
				if_clk_nxt = !if_div_r[1];
			else
				if_clk_nxt = !half_r;
		end
	end

	// Link pulse timer; reception does not gate it
	always @*
	begin
		if (mode_100 || tx_en)
			nlp_cnt_nxt = 24'h000000;
		else if (nlp_hit)
			nlp_cnt_nxt = 24'h000000;
		else
			nlp_cnt_nxt = nlp_cnt_r + 24'h000001;
	end

	always @*
	begin
		mlt_lvl_nxt  = mlt_lvl_r;
		last_pos_nxt = last_pos_r;
		if (mlt_one)
		begin
			mlt_lvl_nxt = mlt_step(mlt_lvl_r, last_pos_r);
			if (mlt_lvl_r == `PLC_LVL_ZERO)
				last_pos_nxt = !last_pos_r;
		end
	end

	always @*
	begin
		if (mode_100)
			line_nxt = mlt_lvl_nxt;
		else if (tx_en)
			line_nxt = man_level(tx_bit, half_r);
		else if (nlp_hit)
			line_nxt = `PLC_LVL_PLUS;
		else
			line_nxt = `PLC_LVL_ZERO;
	end

	always @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			half_r     <= 1'b0;
			bit_idx_r  <= 2'b00;
			tx_en_d_r  <= 1'b0;
			if_div_r   <= 2'b00;
			if_clk_r   <= 1'b0;
			nlp_cnt_r  <= 24'h000000;
			nlp_r      <= 1'b0;
			mlt_lvl_r  <= `PLC_LVL_ZERO;
			last_pos_r <= 1'b0;
			line_tx_r  <= `PLC_LVL_ZERO;
		end
		else
		begin
			half_r     <= half_nxt;
			bit_idx_r  <= bit_idx_nxt;
			tx_en_d_r  <= tx_en;
			if_div_r   <= if_div_nxt;
			if_clk_r   <= if_clk_nxt;
			nlp_cnt_r  <= nlp_cnt_nxt;
			nlp_r      <= nlp_hit;
			mlt_lvl_r  <= mlt_lvl_nxt;
			last_pos_r <= last_pos_nxt;
			line_tx_r  <= line_nxt;
		end
	end

	// ----------------------------------------
	// Receive: decoders and recovered clock
	// ----------------------------------------
	localparam RX_ST_IDLE = 1'b0;
	localparam RX_ST_ON   = 1'b1;

	reg         rx_st_r;
	reg         rx_st_nxt;
	reg  [1:0]  rx_prev_r;
	reg         rx_half_r;
	reg         rx_half_nxt;
	reg         rx_first_r;   // first-half sample
	reg         rx_first_nxt;
	reg  [1:0]  rx_bcnt_r;
	reg  [1:0]  rx_bcnt_nxt;
	reg  [3:0]  rx_shift_r;
	reg  [3:0]  rx_shift_nxt;
	reg  [3:0]  rx_idle_r;
	reg  [3:0]  rx_idle_nxt;
	reg         rx_bit_nxt;
	reg  [3:0]  rx_nib_nxt;

	always @*
	begin
		rx_st_nxt    = rx_st_r;
		rx_half_nxt  = rx_half_r;
		rx_first_nxt = rx_first_r;
		rx_bcnt_nxt  = rx_bcnt_r;
		rx_shift_nxt = rx_shift_r;
		rx_idle_nxt  = rx_idle_r;
		rx_bit_nxt   = rxd_ser_r;
		rx_nib_nxt   = rxd_nib_r;
		if (mode_100)
			rx_st_nxt = RX_ST_IDLE;
		else
		begin
			case (rx_st_r)
			RX_ST_IDLE:
			begin
				if (rx_act)
				begin
					// Sample at the activity edge is the first half of a bit
					rx_st_nxt    = RX_ST_ON;
					rx_half_nxt  = 1'b1;
					rx_bcnt_nxt  = 2'b00;
					rx_idle_nxt  = 4'h0;
					rx_first_nxt = is_high(line_rx);
				end
			end
			RX_ST_ON:
			begin
				rx_half_nxt = !rx_half_r;
				// Recovery lasts until an idle run ends it
				if (rx_act)
					rx_idle_nxt = 4'h0;
				else if (rx_idle_r == RX_IDLE[3:0] - 4'h1)
					rx_st_nxt = RX_ST_IDLE;
				else
					rx_idle_nxt = rx_idle_r + 4'h1;
				if (!rx_half_r)
					rx_first_nxt = is_high(line_rx);
				else
				begin
					// High then low is a one
					rx_bit_nxt   = rx_first_r;
					rx_shift_nxt = {rx_first_r, rx_shift_r[3:1]};
					rx_bcnt_nxt  = rx_bcnt_r + 2'b01;
					if (rx_bcnt_r == 2'b11)
						rx_nib_nxt = {rx_first_r, rx_shift_r[3:1]};
				end
			end
			default:
				rx_st_nxt = RX_ST_IDLE;
			endcase
		end
	end

	always @(posedge mclk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			rx_st_r    <= RX_ST_IDLE;
			rx_prev_r  <= `PLC_LVL_ZERO;
			rx_half_r  <= 1'b0;
			rx_first_r <= 1'b0;
			rx_bcnt_r  <= 2'b00;
			rx_shift_r <= 4'h0;
			rx_idle_r  <= 4'h0;
			rx_nrzi_r  <= 1'b0;
			rxd_ser_r  <= 1'b0;
			rxd_nib_r  <= 4'h0;
			rx_dv_r    <= 1'b0;
			rx_clk_r   <= 1'b0;
			col_r      <= 1'b0;
		end
		else
		begin
			rx_st_r    <= rx_st_nxt;
			rx_half_r  <= rx_half_nxt;
			rx_first_r <= rx_first_nxt;
			rx_bcnt_r  <= rx_bcnt_nxt;
			rx_shift_r <= rx_shift_nxt;
			rx_idle_r  <= rx_idle_nxt;
			rxd_ser_r  <= rx_bit_nxt;
			rxd_nib_r  <= rx_nib_nxt;
			if (mode_100)
				rx_prev_r <= line_rx;
			rx_nrzi_r <= mode_100 && (line_rx != rx_prev_r);
			rx_clk_r  <= !mode_100 && (rx_st_r == RX_ST_ON) && rx_half_r;
			rx_dv_r   <= !mode_100 && (rx_st_r == RX_ST_ON) &&
				(!nibble_if || rx_bcnt_r == 2'b00);
			// Link pulses are not data, so no collision from them
			col_r     <= 1'b0;
		end
	end

endmodule

//--- verification/plc_chk_checker.sv
`include "plc_map.vh"
module plc_chk (
	// Clock and reset
	input logic		mclk,
	input logic		nrst,
	// Inputs
	input logic		mode_100,
	input logic		nibble_if,
	input logic		tx_en,
	input logic		tx_nrzi,
	input logic [1:0]	line_rx,
	// Outputs
	input logic		rx_nrzi_r,
	input logic		if_clk_r,
	input logic		col_r,
	input logic		nlp_r,
	input logic [1:0]	line_tx_r
);
	logic [2:0]	up_r;
	logic [1:0]	m_r;
	logic		m3;
	assign m3 = mode_100 & m_r[0] & m_r[1];
	// Outputs idle after release, so wait before judging
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			up_r <= 3'h0;
		else if (up_r != 3'h7)
			up_r <= up_r + 3'h1;
	always_ff @(posedge mclk)
		m_r <= {m_r[0], mode_100};
	default clocking @(posedge mclk);
	endclocking
	default disable iff (up_r != 3'h7);
	// ----
	// Properties
	// ----
	col_low_a: assert property (!col_r) else $error("col high");
	lvl_code_a: assert property (line_tx_r != 2'h2) else $error("bad level");
	nlp_one_a: assert property (nlp_r |=> !nlp_r) else $error("long pulse");
	nlp_lvl_a: assert property (nlp_r |-> line_tx_r == `PLC_LVL_PLUS) else $error("pulse lvl");
	nlp_tx_a: assert property (tx_en && $past(tx_en) |-> !nlp_r) else $error("pulse in tx");
	nlp_fast_a: assert property (mode_100 && m_r[0] |-> !nlp_r) else $error("pulse at 100");
	mlt_hold_a: assert property (m3 && !($past(tx_en) && $past(tx_nrzi)) |-> $stable(line_tx_r))
		else $error("moved");
	mlt_step_a: assert property (m3 && $past(tx_en) && $past(tx_nrzi) |-> $changed(line_tx_r))
		else $error("held");
	mlt_mid_a: assert property (m3 && $past(tx_en) && $past(tx_nrzi)
		&& $past(line_tx_r) != `PLC_LVL_ZERO
		|-> line_tx_r == `PLC_LVL_ZERO) else $error("skip zero");
	rx_nrzi_a: assert property (m3 |-> rx_nrzi_r == ($past(line_rx) != $past(line_rx, 2)))
		else $error("rx nrzi");
	if_ser_a: assert property (!mode_100 && !m_r[0] && !m_r[1] && !nibble_if
		&& !$past(nibble_if) && !$past(nibble_if, 2)
		|-> if_clk_r != $past(if_clk_r)) else $error("if clk");
endmodule
bind plc_line_coder plc_chk plc_chk_inst (.mclk, .nrst, .mode_100, .nibble_if, .tx_en,
	.tx_nrzi, .line_rx, .rx_nrzi_r, .if_clk_r, .col_r, .nlp_r, .line_tx_r);

//--- verification/plc_mac.sv
module plc_mac (
	// Clock
	input  logic		mclk,
	// Transmit request
	output logic		tx_en,
	output logic [3:0]	txd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		tx_en = 1'b0;
		txd = 4'h0;
	end
	// Serial uses txd[0]; a nibble is held for four bits
	task send(input logic [3:0] d, input int c);
		@(posedge mclk) #1 tx_en = 1'b1;
		txd = d;
		repeat (c) @(posedge mclk);
		#1 tx_en = 1'b0;
		// Stale data must not look valid
		txd = ~d;
	endtask
endmodule

//--- verification/testbench.sv
`define CHK_EQ(n, e, a) \
	begin \
		samples_checked++; \
		if ((e) !== (a)) \
		begin \
			err_total++; \
			$display("unexpected %s exp %h got %h", n, e, a); \
		end \
	end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic		mclk = 1'b0;
	logic		nrst = 1'b0;
	logic		mode_100 = 1'b0;
	logic		nibble_if = 1'b0;
	logic		tx_nrzi = 1'b0;
	logic		rx_act = 1'b0;
	logic [1:0]	line_rx = 2'h0;
	logic		tx_en;
	logic		nlp_r;
	logic [3:0]	txd;
	logic [1:0]	line_tx_r;
	logic		rxd_ser_r;
	logic		rx_clk_r;
	logic [3:0]	rxd_nib_r;
	logic [1:0]	l;
	logic [7:0]	s;
	int		err_total = 0;
	int		samples_checked = 0;
	int		cyc = 0;
	always #50 mclk = ~mclk;
	plc_line_coder #(.NLP_CYC(50)) plc_line_coder_inst (.mclk, .nrst, .mode_100, .nibble_if,
		.tx_en, .txd, .tx_nrzi, .rx_nrzi_r(), .rxd_ser_r, .rxd_nib_r, .rx_dv_r(),
		.rx_clk_r, .if_clk_r(), .col_r(), .line_tx_r, .nlp_r, .line_rx, .rx_act);
	plc_mac plc_mac_inst (.mclk, .tx_en, .txd);
	// ----
	// Scenarios
	// ----
	task results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Start just after a link pulse so none lands in the frame
	task txrun(input logic [3:0] d, input int c);
		int i;
		@(posedge nlp_r);
		@(posedge mclk) #1;
		fork
			plc_mac_inst.send(d, c);
		join_none
		for (i = 0; i < 20 && line_tx_r === 2'h0; i++)
			@(posedge mclk) #1;
		for (i = 0; i < 4; i++)
		begin
			s = {s[5:0], line_tx_r};
			@(posedge mclk) #1;
		end
	endtask
	task t_ser;
		txrun(4'h1, 2);
		`CHK_EQ("ser", 4'h7, s[7:4])
		$display("ser done");
	endtask
	task t_nib;
		nibble_if = 1'b1;
		txrun(4'he, 8);
		`CHK_EQ("nib", 8'hd7, s)
		$display("nib done");
	endtask
	task t_nlp;
		int n;
		rx_act = 1'b1;
		line_rx = 2'h1;
		@(posedge nlp_r);
		n = 0;
		do
		begin
			@(posedge mclk) #1 line_rx ^= 2'h2;
			n++;
		end
		while (nlp_r !== 1'b1 && n < 200);
		`CHK_EQ("gap", 50, n)
		rx_act = 1'b0;
		$display("nlp done");
	endtask
	// Split-phase nibble 9, LSB first, one level per half bit
	task t_rx;
		int i;
		logic [3:0] d;
		d = 4'h9;
		nibble_if = 1'b1;
		repeat (12) @(posedge mclk);
		#1 rx_act = 1'b1;
		for (i = 0; i < 8; i++)
		begin
			line_rx = (d[i / 2] ^ i[0]) ? 2'h1 : 2'h3;
			@(posedge mclk) #1;
		end
		`CHK_EQ("rx nib", 4'h9, rxd_nib_r)
		`CHK_EQ("rx bit", 1'b1, rxd_ser_r)
		`CHK_EQ("rx clk", 1'b1, rx_clk_r)
		rx_act = 1'b0;
		line_rx = 2'h0;
		repeat (12) @(posedge mclk);
		#1;
		`CHK_EQ("rx clk end", 1'b0, rx_clk_r)
		$display("rx done");
	endtask
	task t_mlt;
		mode_100 = 1'b1;
		repeat (3) @(posedge mclk);
		#1 l = line_tx_r;
		fork
			plc_mac_inst.send(4'h0, 6);
		join_none
		@(posedge mclk) #1 tx_nrzi = 1'b1;
		line_rx = 2'h3;
		@(posedge mclk) #1;
		`CHK_EQ("step", 2'h1, line_tx_r)
		repeat (3) @(posedge mclk);
		#1 tx_nrzi = 1'b0;
		`CHK_EQ("cycle", l, line_tx_r)
		repeat (6) @(posedge mclk);
		$display("mlt done");
	endtask
	always @(posedge mclk)
		if (++cyc == 3000)
		begin
			err_total++;
			results;
		end
	initial
	begin
		repeat (16) @(posedge mclk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge mclk);
		t_ser;
		t_nib;
		t_nlp;
		t_rx;
		t_mlt;
		results;
	end
endmodule
